/* File: design/lpms_sequencer.sv */
// Low-power mode sequencer with APB register file
// How it works
// - run keeps core, modules, plls, oscillators on
// - wait gates core clock only
// - stop gates core, modules; plls off
// - dormant powers core off; only slow clock
// - standby request enters stop, memory self-refresh
// - suspend request enters dormant, memory self-refresh
// - idle condition enters wait mode
// - control programmed first; power-down per mode
// - dormant saves context, lowers ddr drive
// - unmasked wakeup ends state, restores dormant
// - dormant may raise standby voltage request
// - pmic on output follows always-on control; here also gated by the software enable register
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module lpms_sequencer
   import lpms_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   deepSleepReq,
   input  wire logic                   waitForInterrupt,
   input  wire logic                   systemIdle,
   input  wire logic                   contextSaved,
   input  wire logic [lpms_pkg::LPMS_NWAKE-1:0] wakeIrq,
   input  wire logic                   pmicOnCtrl,
   output logic                        coreClkEn,
   output logic                        moduleClkEn,
   output logic                        pllEn,
   output logic                        fastOscEn,
   output logic                        slowClkEn,
   output logic                        corePwrEn,
   output logic                        memPeriphPwrEn,
   output logic                        powerDownReq,
   output logic                        ddrSelfRefresh,
   output logic                        ddrPadDriveLow,
   output logic                        contextSaveReq,
   output logic                        contextRestoreReq,
   output logic                        standby_voltage_request,
   output logic                        pmicOnReq,
   output logic                        irq
);
   lpms_state_t                 stateReg;
   lpms_mode_t                  modeReg;
   logic [31:0]                 ctrlReg;
   logic [LPMS_NWAKE-1:0]       wakeMaskReg;
   logic [2:0]                  irqStatReg;
   logic [2:0]                  irqMaskReg;
   logic                        pmicSwReg;
   logic [2:0]                  stepCntReg;
   logic [LPMS_NWAKE-1:0]       wakeSync;
   logic [1:0]                  reqSync;
   logic                        wfiSync;
   logic                        idleSync;
   logic                        savedSync;
   logic                        pmicSync;
   logic                        wakeHit;
   logic                        apbWr;
   logic                        addrOk;
   logic                        evEnter;
   logic                        evWake;
   logic                        evRefused;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   lpms_wake_sync #(.WIDTH(LPMS_NWAKE)) uWake (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .asyncIn (wakeIrq),
      .syncOut (wakeSync)
   );
   lpms_wake_sync #(.WIDTH(6)) uCtl (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .asyncIn ({deepSleepReq, waitForInterrupt, systemIdle, contextSaved, pmicOnCtrl,
                 1'b0}),
      .syncOut ({reqSync[0], wfiSync, idleSync, savedSync, pmicSync, reqSync[1]})
   );

   // Wakeup only from sources unmasked (mask bit 0 = enabled)
   assign wakeHit = |(wakeSync & ~wakeMaskReg);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   function automatic logic addrValid(input logic [7:0] a);
      addrValid = (a == LPMS_OFF_CTRL) || (a == LPMS_OFF_MODE) ||
                  (a == LPMS_OFF_WKMASK) || (a == LPMS_OFF_STATUS) ||
                  (a == LPMS_OFF_IRQST) || (a == LPMS_OFF_IRQMSK) ||
                  (a == LPMS_OFF_PMIC);
   endfunction

   assign addrOk  = addrValid(paddr);
   assign apbWr   = psel && penable && pwrite && addrOk;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addrOk;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            LPMS_OFF_CTRL:   prdata <= ctrlReg;
            LPMS_OFF_MODE:   prdata <= {30'h0000_0000, modeReg};
            LPMS_OFF_WKMASK: prdata <= {24'h00_0000, wakeMaskReg};
            LPMS_OFF_STATUS: prdata <= {21'h00_0000, wakeSync, stateReg};
            LPMS_OFF_IRQST:  prdata <= {29'h0000_0000, irqStatReg};
            LPMS_OFF_IRQMSK: prdata <= {29'h0000_0000, irqMaskReg};
            LPMS_OFF_PMIC:   prdata <= {31'h0000_0000, pmicSwReg};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Low-power control register, programmed before entry
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrlReg <= LPMS_CTRL_RST;
         modeReg <= LPMS_MODE_RUN;
      end else if (apbWr && paddr == LPMS_OFF_CTRL) begin
         ctrlReg <= {30'h0000_0000, pwdata[1:0]};
      end else if (apbWr && paddr == LPMS_OFF_MODE && stateReg == LPMS_ST_RUN) begin
         modeReg <= lpms_mode_t'(pwdata[LPMS_MODE_LSB +: 2]);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wakeMaskReg <= LPMS_WKMASK_RST;
         irqMaskReg  <= LPMS_IRQMSK_RST;
         pmicSwReg   <= LPMS_PMIC_ON_RST;
      end else if (apbWr) begin
         if (paddr == LPMS_OFF_WKMASK) wakeMaskReg <= pwdata[LPMS_NWAKE-1:0];
         if (paddr == LPMS_OFF_IRQMSK) irqMaskReg  <= pwdata[2:0];
         if (paddr == LPMS_OFF_PMIC)   pmicSwReg   <= pwdata[0];
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stateReg   <= LPMS_ST_RUN;
         stepCntReg <= 3'd0;
      end else begin
         case (stateReg)
            LPMS_ST_RUN: begin
               stepCntReg <= 3'd0;
               if (reqSync[0] && ctrlReg[LPMS_CTRL_SLEEPEN] && wfiSync) begin
                  if (modeReg == LPMS_MODE_DORMANT)
                     stateReg <= LPMS_ST_SAVE;
                  else if (modeReg == LPMS_MODE_STOP)
                     stateReg <= LPMS_ST_LOWPWR;
                  else if (modeReg == LPMS_MODE_WAIT || idleSync)
                     stateReg <= LPMS_ST_WAIT;
               end else if (reqSync[0] && wfiSync && idleSync) begin
                  stateReg <= LPMS_ST_WAIT;
               end
            end
            LPMS_ST_SAVE: begin
               if (savedSync) stateReg <= LPMS_ST_LOWPWR;
            end
            LPMS_ST_LOWPWR: begin
               if (wakeHit) stateReg <= LPMS_ST_RESTORE;
            end
            LPMS_ST_WAIT: begin
               if (wakeHit) stateReg <= LPMS_ST_RUN;
            end
            LPMS_ST_RESTORE: begin
               if (stepCntReg == 3'(LPMS_STEP_CYCLES - 1)) begin
                  stateReg <= LPMS_ST_RUN;
               end else begin
                  stepCntReg <= stepCntReg + 3'd1;
               end
            end
            default: stateReg <= LPMS_ST_RUN;
         endcase
      end
   end

   // ----------------------------------------
   // Clock and power outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         coreClkEn         <= 1'b1;
         moduleClkEn       <= 1'b1;
         pllEn             <= 1'b1;
         fastOscEn         <= 1'b1;
         slowClkEn         <= 1'b1;
         corePwrEn         <= 1'b1;
         memPeriphPwrEn    <= 1'b1;
         powerDownReq      <= 1'b0;
         ddrSelfRefresh    <= 1'b0;
         ddrPadDriveLow    <= 1'b0;
         contextSaveReq    <= 1'b0;
         contextRestoreReq <= 1'b0;
         standby_voltage_request <= 1'b0;
      end else begin
         slowClkEn         <= 1'b1;
         coreClkEn         <= (stateReg == LPMS_ST_RUN) ||
                              (stateReg == LPMS_ST_SAVE);
         moduleClkEn       <= stateReg != LPMS_ST_LOWPWR;
         pllEn             <= stateReg != LPMS_ST_LOWPWR;
         fastOscEn         <= !(stateReg == LPMS_ST_LOWPWR &&
                                modeReg == LPMS_MODE_DORMANT);
         powerDownReq      <= stateReg == LPMS_ST_LOWPWR;
         corePwrEn         <= !(stateReg == LPMS_ST_LOWPWR &&
                                modeReg == LPMS_MODE_DORMANT);
         memPeriphPwrEn    <= stateReg != LPMS_ST_LOWPWR;
         ddrSelfRefresh    <= stateReg == LPMS_ST_LOWPWR;
         ddrPadDriveLow    <= stateReg == LPMS_ST_LOWPWR &&
                              modeReg == LPMS_MODE_DORMANT;
         contextSaveReq    <= stateReg == LPMS_ST_SAVE;
         contextRestoreReq <= stateReg == LPMS_ST_RESTORE &&
                              modeReg == LPMS_MODE_DORMANT;
         standby_voltage_request <= stateReg == LPMS_ST_LOWPWR &&
                                    modeReg == LPMS_MODE_DORMANT &&
                                    ctrlReg[LPMS_CTRL_VSTBYEN];
      end
   end

   // PMIC on request from the always-on control and software enable
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pmicOnReq <= LPMS_PMIC_ON_RST;
      end else begin
         pmicOnReq <= pmicSync && pmicSwReg;
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign evEnter   = stateReg == LPMS_ST_RUN && reqSync[0] && wfiSync &&
                      ctrlReg[LPMS_CTRL_SLEEPEN] && modeReg != LPMS_MODE_RUN;
   assign evWake    = (stateReg == LPMS_ST_LOWPWR || stateReg == LPMS_ST_WAIT) && wakeHit;
   assign evRefused = stateReg == LPMS_ST_RUN && reqSync[0] && wfiSync &&
                      !ctrlReg[LPMS_CTRL_SLEEPEN] && !idleSync;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irqStatReg <= 3'h0;
      end else begin
         irqStatReg <= (irqStatReg &
                        ~((apbWr && paddr == LPMS_OFF_IRQST) ? pwdata[2:0] : 3'h0)) |
                       {evRefused, evWake, evEnter};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatReg & irqMaskReg);
      end
   end
endmodule

/* File: design/lpms_wake_sync.sv */
// Two-flop synchroniser for wakeup interrupt lines
`timescale 1ns/10ps
module lpms_wake_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1Reg;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               stage1Reg[i] <= 1'b0;
               syncOut[i]   <= 1'b0;
            end else begin
               stage1Reg[i] <= asyncIn[i];
               syncOut[i]   <= stage1Reg[i];
            end
         end
      end
   endgenerate
endmodule

/* File: shared/lpms_pkg.sv */
// Package of constants and types for the low-power mode sequencer
package lpms_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] LPMS_OFF_CTRL   = 8'h00;
   localparam logic [7:0] LPMS_OFF_MODE   = 8'h04;
   localparam logic [7:0] LPMS_OFF_WKMASK = 8'h08;
   localparam logic [7:0] LPMS_OFF_STATUS = 8'h0C;
   localparam logic [7:0] LPMS_OFF_IRQST  = 8'h10;
   localparam logic [7:0] LPMS_OFF_IRQMSK = 8'h14;
   localparam logic [7:0] LPMS_OFF_PMIC   = 8'h18;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int LPMS_CTRL_SLEEPEN = 0;
   localparam int LPMS_CTRL_VSTBYEN = 1;
   localparam int LPMS_MODE_LSB     = 0;
   localparam int LPMS_IRQ_ENTER    = 0;
   localparam int LPMS_IRQ_WAKE     = 1;
   localparam int LPMS_IRQ_REFUSED  = 2;
   // ----------------------------------------
   // Reset values and sizes
   // ----------------------------------------
   localparam int          LPMS_NWAKE        = 8;
   localparam logic [31:0] LPMS_CTRL_RST     = 32'h0000_0000;
   localparam logic [7:0]  LPMS_WKMASK_RST   = 8'hFF;
   localparam logic [2:0]  LPMS_IRQMSK_RST   = 3'h0;
   localparam logic        LPMS_PMIC_ON_RST  = 1'b1;
   localparam int          LPMS_STEP_CYCLES  = 4;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      LPMS_MODE_RUN, LPMS_MODE_WAIT, LPMS_MODE_STOP, LPMS_MODE_DORMANT
   } lpms_mode_t;
   typedef enum logic [2:0] {
      LPMS_ST_RUN, LPMS_ST_SAVE, LPMS_ST_LOWPWR, LPMS_ST_RESTORE, LPMS_ST_WAIT
   } lpms_state_t;
endpackage

/* File: tb/lpms_core_pmic_model.sv */
// Model of the processor core and the external PMIC
`timescale 1ns/10ps
module lpms_core_pmic_model #(
   parameter int SAVE_DLY = 3
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic sleepCmd,
   input  wire logic contextSaveReq,
   input  wire logic pmicOnReq,
   output logic      deepSleepReq,
   output logic      waitForInterrupt,
   output logic      contextSaved,
   output logic      pmicPowered
);
   int saveCnt;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         deepSleepReq <= 1'b0;
         waitForInterrupt <= 1'b0;
      end else begin
         deepSleepReq <= sleepCmd;
         waitForInterrupt <= sleepCmd && deepSleepReq;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         saveCnt <= 0;
         contextSaved <= 1'b0;
      end else begin
         saveCnt <= contextSaveReq ? saveCnt + 1 : 0;
         contextSaved <= contextSaveReq && saveCnt >= SAVE_DLY;
      end
   end
   always_ff @(posedge clk_sys) begin
      pmicPowered <= pmicOnReq;
   end
endmodule

/* File: tb/lpms_sequencer_props.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/10ps
module lpms_sequencer_props (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic pmicOnCtrl,
   input wire logic pmicOnReq,
   input wire logic coreClkEn,
   input wire logic moduleClkEn,
   input wire logic pllEn,
   input wire logic fastOscEn,
   input wire logic slowClkEn,
   input wire logic corePwrEn,
   input wire logic memPeriphPwrEn,
   input wire logic powerDownReq,
   input wire logic ddrSelfRefresh,
   input wire logic ddrPadDriveLow,
   input wire logic contextRestoreReq,
   input wire logic standby_voltage_request
);
   // ----------------------------------------
   // Mode relations
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_run; coreClkEn |-> moduleClkEn && pllEn && fastOscEn && corePwrEn; endproperty
   a_run: assert property (p_run) else $error("core clocked without full run");
   property p_wait; !coreClkEn && pllEn |-> fastOscEn && corePwrEn && slowClkEn; endproperty
   a_wait: assert property (p_wait) else $error("wait lost a source");
   property p_stop; !pllEn |-> !coreClkEn && !moduleClkEn && slowClkEn; endproperty
   a_stop: assert property (p_stop) else $error("plls off with clocks on");
   property p_dorm; !fastOscEn |-> !corePwrEn && !pllEn && slowClkEn; endproperty
   a_dorm: assert property (p_dorm) else $error("oscillator off outside dormant");
   property p_selfRef; ddrSelfRefresh |-> !pllEn && powerDownReq; endproperty
   a_selfRef: assert property (p_selfRef) else $error("self refresh outside stop");
   property p_pdn; !corePwrEn |-> powerDownReq && !memPeriphPwrEn; endproperty
   a_pdn: assert property (p_pdn) else $error("core off without power down");
   property p_standby_voltage_request; standby_voltage_request |-> !corePwrEn; endproperty
   a_standby_voltage_request: assert property (p_standby_voltage_request) else $error("standby voltage outside dormant");
   property p_restore;
      $rose(coreClkEn) |-> ##[0:8] (!ddrPadDriveLow && !ddrSelfRefresh && corePwrEn && pllEn);
   endproperty
   a_restore: assert property (p_restore) else $error("run not restored");
   property p_ctxRest; $fell(ddrPadDriveLow) |-> contextRestoreReq; endproperty
   a_ctxRest: assert property (p_ctxRest) else $error("core state not restored");
   property p_pmic; !pmicOnCtrl [*5] |-> !pmicOnReq; endproperty
   a_pmic: assert property (p_pmic) else $error("pmic request stayed on");
   c_stop: cover property ($fell(pllEn));
   c_dorm: cover property ($fell(corePwrEn));
   c_wake: cover property ($rose(coreClkEn));
endmodule

/* File: tb/test_lpms_sequencer.sv */
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value at %0t got %h expected %h", $time, a, e); end end
module test_lpms_sequencer;
   import lpms_pkg::*;
   logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, err, irq;
   logic systemIdle, pmicOnCtrl, pmicOnReq, sleepCmd, pmicPowered;
   logic deepSleepReq, waitForInterrupt, contextSaved, contextSaveReq, contextRestoreReq;
   logic coreClkEn, moduleClkEn, pllEn, fastOscEn, slowClkEn, corePwrEn, memPeriphPwrEn;
   logic powerDownReq, ddrSelfRefresh, ddrPadDriveLow, standby_voltage_request;
   logic [7:0]             paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic [LPMS_NWAKE-1:0]  wakeIrq;
   logic [10:0]            expOut [4] = '{11'h7F0, 11'h3F0, 11'h0EC, 11'h04F};
   int                     checkCount, miscompares, n;
   wire  [10:0]            outs = {coreClkEn, moduleClkEn, pllEn, fastOscEn, slowClkEn,
      corePwrEn, memPeriphPwrEn, powerDownReq, ddrSelfRefresh, ddrPadDriveLow,
      standby_voltage_request};
   lpms_sequencer DUT (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .deepSleepReq, .waitForInterrupt, .systemIdle, .contextSaved,
      .wakeIrq, .pmicOnCtrl, .coreClkEn, .moduleClkEn, .pllEn, .fastOscEn, .slowClkEn,
      .corePwrEn, .memPeriphPwrEn, .powerDownReq, .ddrSelfRefresh, .ddrPadDriveLow,
      .contextSaveReq, .contextRestoreReq, .standby_voltage_request, .pmicOnReq, .irq);
   lpms_core_pmic_model #(.SAVE_DLY(3)) u_model (.clk_sys, .rst_b, .sleepCmd,
      .contextSaveReq, .pmicOnReq, .deepSleepReq, .waitForInterrupt, .contextSaved,
      .pmicPowered);
   // ----------------------------------------
   // Bus tasks and run control
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic waitState(input logic [2:0] s);
      n = 0;
      do apb(1'b0, LPMS_OFF_STATUS, 32'h0); while (rd[2:0] !== s && ++n < 100);
      `CHK(rd[2:0], s)
   endtask
   task automatic end_sim;
      $display("checks %0d miscompares %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      end_sim();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
      pwdata = 32'h0; systemIdle = 1'b0; pmicOnCtrl = 1'b1; sleepCmd = 1'b0; wakeIrq = '0;
      repeat (2) @(posedge clk_sys);
      `CHK(outs, expOut[0])
      rst_b <= 1'b1;
      rdChk(LPMS_OFF_CTRL, 32'h0);
      rdChk(LPMS_OFF_WKMASK, 32'h0000_00FF);
      rdChk(LPMS_OFF_PMIC, 32'h1);
      rdChk(8'h1C, 32'h0);
      `CHK(err, 1'b1)
      sleepCmd <= 1'b1;
      repeat (12) @(posedge clk_sys);
      sleepCmd <= 1'b0;
      rdChk(LPMS_OFF_STATUS, 32'h0);
      rdChk(LPMS_OFF_IRQST, 32'h4);
      `CHK(irq, 1'b0)
      apb(1'b1, LPMS_OFF_IRQMSK, 32'h7);
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 1'b1)
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, LPMS_OFF_IRQST, 32'h7);
         apb(1'b1, LPMS_OFF_CTRL, m == 0 ? 32'h0 : 32'h3);
         apb(1'b1, LPMS_OFF_MODE, m);
         apb(1'b1, LPMS_OFF_WKMASK, 32'h0000_00FE);
         systemIdle <= (m == 0);
         sleepCmd <= 1'b1;
         waitState(m > 1 ? 3'h2 : 3'h4);
         sleepCmd <= 1'b0;
         systemIdle <= 1'b0;
         repeat (2) @(posedge clk_sys);
         `CHK(outs, expOut[m == 0 ? 1 : m])
         `CHK(irq, m != 0)
         wakeIrq <= 8'h02;
         repeat (12) @(posedge clk_sys);
         apb(1'b0, LPMS_OFF_STATUS, 32'h0);
         `CHK(rd[2:0], m > 1 ? 3'h2 : 3'h4)
         wakeIrq <= 8'h01;
         waitState(3'h0);
         rdChk(LPMS_OFF_IRQST, m == 0 ? 32'h2 : 32'h3);
         wakeIrq <= 8'h00;
         repeat (2) @(posedge clk_sys);
         `CHK(outs, expOut[0])
      end
      apb(1'b1, LPMS_OFF_IRQST, 32'h7);
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 1'b0)
      apb(1'b1, LPMS_OFF_PMIC, 32'h0);
      repeat (6) @(posedge clk_sys);
      `CHK(pmicPowered, 1'b0)
      apb(1'b1, LPMS_OFF_PMIC, 32'h1);
      repeat (6) @(posedge clk_sys);
      `CHK(pmicPowered, 1'b1)
      pmicOnCtrl <= 1'b0;
      repeat (8) @(posedge clk_sys);
      `CHK(pmicPowered, 1'b0)
      end_sim();
   end
endmodule
bind lpms_sequencer lpms_sequencer_props u_props (.clk_sys, .rst_b, .pmicOnCtrl, .pmicOnReq,
   .coreClkEn, .moduleClkEn, .pllEn, .fastOscEn, .slowClkEn, .corePwrEn, .memPeriphPwrEn,
   .powerDownReq, .ddrSelfRefresh, .ddrPadDriveLow, .contextRestoreReq,
   .standby_voltage_request);
